// file: inc/vwo_pkg.sv
// vwo_pkg: register indices, field positions, reset values and format codes
// of the video overlay window control block.
// assumes an indexed 8-bit register port and a display clock of 250 MHz.
package vwo_pkg;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] VWO_IDX_VSTART_LOW = 8'h37;
  localparam logic [7:0] VWO_IDX_VEND_LOW = 8'h38;
  localparam logic [7:0] VWO_IDX_VERT_OVF = 8'h39;
  localparam logic [7:0] VWO_IDX_B1_BYTE0 = 8'h3a;
  localparam logic [7:0] VWO_IDX_B1_BYTE1 = 8'h3b;
  localparam logic [7:0] VWO_IDX_B1_BYTE2 = 8'h3c;
  localparam logic [7:0] VWO_IDX_LINE_OFFSET = 8'h3d;
  localparam logic [7:0] VWO_IDX_MASTER_CTL = 8'h3e;
  localparam logic [7:0] VWO_IDX_MISC_CTL = 8'h3f;
  localparam logic [7:0] VWO_IDX_B2_HIGH = 8'h58;
  localparam logic [7:0] VWO_IDX_B2_BYTE0 = 8'h59;
  localparam logic [7:0] VWO_IDX_B2_BYTE1 = 8'h5a;
  localparam logic [7:0] VWO_IDX_LUMA_ONLY = 8'h5c;
  localparam logic [7:0] VWO_IDX_PIX_ALIGN = 8'h5d;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int VWO_B1_OFFS11_BIT = 5;   // offset bit 11 inside byte 2
  localparam int VWO_MC_OCCL_BIT = 7;
  localparam int VWO_MC_DIFF_BIT = 5;
  localparam int VWO_MC_ZOOM_BIT = 4;
  localparam int VWO_MC_FMT_LSB = 1;
  localparam int VWO_MC_EN_BIT = 0;
  localparam int VWO_MS_REF_BIT = 7;
  localparam int VWO_MS_FIELD_BIT = 6;
  localparam int VWO_MS_SRC_BIT = 5;
  localparam int VWO_MS_ADEC_BIT = 4;
  localparam int VWO_MS_CAPBUF_BIT = 2;
  localparam int VWO_MS_IRQEN_BIT = 1;
  localparam int VWO_MS_PAGE_BIT = 0;
  localparam int VWO_LUMA_BIT = 7;

  // ----------------------------------------------------------------------
  // display format codes and constants
  // ----------------------------------------------------------------------
  localparam logic [2:0] VWO_FMT_YUV422 = 3'h0;
  localparam logic [2:0] VWO_FMT_COMPRESSED = 3'h1;
  localparam logic [2:0] VWO_FMT_LUT8 = 3'h2;
  localparam logic [2:0] VWO_FMT_RGB555 = 3'h4;
  localparam logic [2:0] VWO_FMT_RGB565 = 3'h5;
  localparam logic [21:0] VWO_LUMA_OFFSET = 22'h00_0400;  // 1024 bytes
  localparam logic [7:0] VWO_REG_RESET = 8'h00;
  localparam logic [3:0] VWO_BE_WORD_LOW = 4'h3;
  localparam logic [3:0] VWO_BE_DWORD = 4'hf;

endpackage

// file: design/vwo_control.sv
// vwo_control: register file and address logic of the video overlay window.
// assumes vsync, line strobe and aperture writes come from logic on clk_sys;
// the field reference pin is asynchronous and is synchronised here.
//
// Operation
// - vertical start: low byte plus overflow bits
// - vertical end: low byte plus overflow bits
// - buffer one address from four register pieces
// - buffer two built alike; capture/display defaults
// - capture addresses ignore alignment low bits
// - double buffering swaps buffer one's role
// - 12-bit line offset, low three bits zero
// - add offset at each window line end
// - interleaved capture uses twice the offset
// - luma-only capture forces 1024-byte offset
// - occlusion bit enables per-pixel overlay
// - error diffusion bit fills low luma bits
// - zoom bit: replicate or interpolate, no interpolate+occlusion
// - decode three-bit display format field
// - enable waits vsync edge, disable immediate
// - status bit follows field reference level
// - field id toggles on field reference edge
// - select irq source: vsync or field reference
// - auto-decimation in RGB formats drops high word, halves offset
// - auto-decimation with format zero: YUV12 assist
// - field reference irq pending, cleared by enable zero
module vwo_control
  import vwo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] io_index,     // register index
  input wire logic [7:0] io_wdata,     // write data
  input wire logic io_wr,              // one-cycle write strobe
  input wire logic io_rd,              // one-cycle read strobe
  output logic [7:0] io_rdata,         // read data, one cycle after io_rd
  input wire logic vsync,              // vertical sync level
  input wire logic line_strobe,        // end of scanline pulse
  input wire logic field_ref_pin,      // asynchronous field reference
  input wire logic dbl_buf_en,         // double buffering active
  input wire logic cap_interleave,     // interleaved capture addressing
  input wire logic cap_line_end,       // end of captured line pulse
  input wire logic ap_wr,              // aperture write request
  input wire logic [21:0] ap_offset,   // byte offset within aperture
  input wire logic [3:0] ap_be,        // byte enables
  input wire logic [31:0] ap_data,     // write data
  output logic mem_wr,
  output logic [21:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_data,
  output logic window_active,          // current scanline inside window
  output logic [21:0] window_addr,     // current window line address
  output logic [21:0] capture_addr,    // current capture line address
  output logic capture_buf_one,        // capture goes to buffer one
  output logic occlusion_en,
  output logic err_diffusion_en,
  output logic zoom_replicate,         // one: replicate, zero: interpolate
  output logic cfg_conflict,           // interpolation with occlusion
  output logic [5:0] fmt_sel,          // one-hot decoded display format
  output logic yuv12_assist,
  output logic host_irq_pin,           // interrupt request, active high
  output logic irq_pending_reg         // field reference irq pending
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] vstart_lo;
    logic [7:0] vend_lo;
    logic [3:0] vovf;
    logic [7:0] b1_b0;
    logic [7:0] b1_b1;
    logic [7:0] b1_b2;
    logic [7:0] offs_lo;
    logic [7:0] mctl;
    logic [5:0] misc;        // bits 5:0 of the misc register, bit 3 unused
    logic [3:0] b2_hi;
    logic [7:0] b2_b0;
    logic [7:0] b2_b1;
    logic luma_only;
    logic [3:0] align;
    logic ref_s1;            // synchroniser first stage
    logic ref_s2;            // synchroniser second stage
    logic ref_prev;          // previous synchronised level
    logic field_id;
    logic win_en;            // effective window enable
    logic vsync_prev;
    logic [9:0] line_cnt;
    logic [7:0] rdata;
    logic win_act;
    logic [21:0] win_addr;
    logic [21:0] cap_addr;
    logic cap_sel;
    logic pend;
    logic irq;
    logic m_wr;
    logic [21:0] m_addr;
    logic [3:0] m_be;
    logic [31:0] m_data;
    logic occl;
    logic diff;
    logic zrep;
    logic confl;
    logic [5:0] fmt;
    logic y12;
  } vwo_state_t;

  vwo_state_t s;        // registered state
  vwo_state_t next_s;   // next state

  // ----------------------------------------------------------------------
  // derived values
  // ----------------------------------------------------------------------
  logic [9:0] vstart;
  logic [9:0] vend;
  logic [21:0] b1_start;
  logic [21:0] b2_start;
  logic [21:0] line_offs;
  logic [21:0] cap_offs;
  logic [2:0] fmt_code;
  logic ref_fall;
  logic vs_rise;
  logic adec_rgb;

  assign vstart = {s.vovf[1:0], s.vstart_lo};
  assign vend = {s.vovf[3:2], s.vend_lo};
  // byte start addresses, shared alignment bits
  assign b1_start = {s.b1_b2[3:0], s.b1_b1, s.b1_b0, s.align[3:2]};
  assign b2_start = {s.b2_hi, s.b2_b1, s.b2_b0, s.align[3:2]};
  // 12-bit offset with three zero bits
  assign line_offs = {10'h000, s.b1_b2[VWO_B1_OFFS11_BIT], s.offs_lo, 3'h0};
  // capture step: luma-only wins, else interleave doubles
  assign cap_offs = s.luma_only ? VWO_LUMA_OFFSET
                  : (cap_interleave ? {line_offs[20:0], 1'b0} : line_offs);
  assign fmt_code = s.mctl[VWO_MC_FMT_LSB +: 3];
  assign ref_fall = s.ref_prev & ~s.ref_s2;     // active edge of reference
  assign vs_rise = vsync & ~s.vsync_prev;       // leading edge of vsync
  assign adec_rgb = s.misc[VWO_MS_ADEC_BIT] &
                    ((fmt_code == VWO_FMT_RGB555) | (fmt_code == VWO_FMT_RGB565));

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // one pass builds the whole next state from s and the inputs
  always_comb begin
    next_s = s;
    // synchroniser and edge history
    next_s.ref_s1 = field_ref_pin;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_prev = s.ref_s2;
    next_s.vsync_prev = vsync;
    // register writes
    if (io_wr) begin
      case (io_index)
        VWO_IDX_VSTART_LOW: next_s.vstart_lo = io_wdata;
        VWO_IDX_VEND_LOW: next_s.vend_lo = io_wdata;
        VWO_IDX_VERT_OVF: next_s.vovf = io_wdata[3:0];
        VWO_IDX_B1_BYTE0: next_s.b1_b0 = io_wdata;
        VWO_IDX_B1_BYTE1: next_s.b1_b1 = io_wdata;
        VWO_IDX_B1_BYTE2: next_s.b1_b2 = {2'h0, io_wdata[5], 1'b0, io_wdata[3:0]};
        VWO_IDX_LINE_OFFSET: next_s.offs_lo = io_wdata;
        VWO_IDX_MASTER_CTL: next_s.mctl = {io_wdata[7], 1'b0, io_wdata[5:0]};
        // bit 3 is kept zero whatever software writes
        VWO_IDX_MISC_CTL: next_s.misc = {io_wdata[5:4], 1'b0, 1'b0, io_wdata[1:0]};
        VWO_IDX_B2_HIGH: next_s.b2_hi = io_wdata[3:0];
        VWO_IDX_B2_BYTE0: next_s.b2_b0 = io_wdata;
        VWO_IDX_B2_BYTE1: next_s.b2_b1 = io_wdata;
        VWO_IDX_LUMA_ONLY: next_s.luma_only = io_wdata[VWO_LUMA_BIT];
        VWO_IDX_PIX_ALIGN: next_s.align = io_wdata[3:0];
        default: next_s.rdata = s.rdata;   // unmapped index: write ignored
      endcase
    end
    // register reads, unmapped and reserved bits read zero
    if (io_rd) begin
      case (io_index)
        VWO_IDX_VSTART_LOW: next_s.rdata = s.vstart_lo;
        VWO_IDX_VEND_LOW: next_s.rdata = s.vend_lo;
        VWO_IDX_VERT_OVF: next_s.rdata = {4'h0, s.vovf};
        VWO_IDX_B1_BYTE0: next_s.rdata = s.b1_b0;
        VWO_IDX_B1_BYTE1: next_s.rdata = s.b1_b1;
        VWO_IDX_B1_BYTE2: next_s.rdata = s.b1_b2;
        VWO_IDX_LINE_OFFSET: next_s.rdata = s.offs_lo;
        VWO_IDX_MASTER_CTL: next_s.rdata = s.mctl;
        // live reference level and field id
        VWO_IDX_MISC_CTL: next_s.rdata = {s.ref_s2, s.field_id, s.misc[5:3],
                                          s.cap_sel, s.misc[1:0]};
        VWO_IDX_B2_HIGH: next_s.rdata = {4'h0, s.b2_hi};
        VWO_IDX_B2_BYTE0: next_s.rdata = s.b2_b0;
        VWO_IDX_B2_BYTE1: next_s.rdata = s.b2_b1;
        VWO_IDX_LUMA_ONLY: next_s.rdata = {s.luma_only, 7'h00};
        VWO_IDX_PIX_ALIGN: next_s.rdata = {4'h0, s.align};
        default: next_s.rdata = 8'h00;
      endcase
    end
    // field id toggles on each active reference edge
    if (ref_fall) begin
      next_s.field_id = ~s.field_id;
    end
    // window enable: off at once, on only at vsync leading edge
    if (!s.mctl[VWO_MC_EN_BIT]) begin
      next_s.win_en = 1'b0;
    end else if (vs_rise) begin
      next_s.win_en = 1'b1;
    end
    // scanline counter restarts at vsync
    if (vs_rise) begin
      next_s.line_cnt = 10'h000;
    end else if (line_strobe) begin
      next_s.line_cnt = s.line_cnt + 10'h001;
    end
    // scanline bounded by start and end inclusive
    next_s.win_act = s.win_en & (next_s.line_cnt >= vstart) &
                     (next_s.line_cnt <= vend);
    // window address: display buffer start at frame, add offset per line
    if (vs_rise) begin
      next_s.win_addr = s.cap_sel ? b2_start : b1_start;
    end else if (line_strobe && s.win_act) begin
      next_s.win_addr = s.win_addr + line_offs;
    end
    // capture buffer swaps at each field when double buffered
    if (ref_fall) begin
      next_s.cap_sel = dbl_buf_en ? ~s.cap_sel : 1'b0;
      // dword-aligned capture start
      next_s.cap_addr = (next_s.cap_sel ? b1_start : b2_start) & 22'h3f_fffc;
    end else if (cap_line_end) begin
      next_s.cap_addr = (s.cap_addr + cap_offs) & 22'h3f_fffc;
    end
    // pending flag: a disabled bit wins over set, nothing else clears it
    if (!s.misc[VWO_MS_IRQEN_BIT]) begin
      next_s.pend = 1'b0;
    end else if (ref_fall) begin
      next_s.pend = 1'b1;
    end
    // request source: vsync level or field reference flag
    next_s.irq = s.misc[VWO_MS_SRC_BIT] ? s.pend : vsync;
    // mode decode
    next_s.occl = s.mctl[VWO_MC_OCCL_BIT];
    next_s.diff = s.mctl[VWO_MC_DIFF_BIT];
    next_s.zrep = s.mctl[VWO_MC_ZOOM_BIT];
    next_s.confl = s.mctl[VWO_MC_OCCL_BIT] & ~s.mctl[VWO_MC_ZOOM_BIT];
    // one-hot format, bit 5 flags a reserved code
    case (fmt_code)
      VWO_FMT_YUV422: next_s.fmt = 6'h01;
      VWO_FMT_COMPRESSED: next_s.fmt = 6'h02;
      VWO_FMT_LUT8: next_s.fmt = 6'h04;
      VWO_FMT_RGB555: next_s.fmt = 6'h08;
      VWO_FMT_RGB565: next_s.fmt = 6'h10;
      default: next_s.fmt = 6'h20;
    endcase
    // planar assist with format zero
    next_s.y12 = s.misc[VWO_MS_ADEC_BIT] & (fmt_code == VWO_FMT_YUV422);
    // aperture writes, decimated in RGB mode
    next_s.m_wr = 1'b0;
    if (ap_wr) begin
      if (adec_rgb) begin
        // keep low word only, halve offset, page bit replaces A21
        next_s.m_wr = (ap_be == VWO_BE_WORD_LOW) | (ap_be == VWO_BE_DWORD);
        next_s.m_addr = {s.misc[VWO_MS_PAGE_BIT], ap_offset[21:1]};
        next_s.m_be = {2'h0, ap_be[1:0]};
        next_s.m_data = {16'h0000, ap_data[15:0]};
      end else begin
        next_s.m_wr = 1'b1;
        next_s.m_addr = ap_offset;
        next_s.m_be = ap_be;
        next_s.m_data = ap_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // reset clears every field; fmt_sel then shows the yuv code
  // from the first edge after release, since format zero is yuv
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // each output is a state field, no logic after the flops
  assign io_rdata = s.rdata;
  assign mem_wr = s.m_wr;
  assign mem_addr = s.m_addr;
  assign mem_be = s.m_be;
  assign mem_data = s.m_data;
  assign window_active = s.win_act;
  assign window_addr = s.win_addr;
  assign capture_addr = s.cap_addr;
  assign capture_buf_one = s.cap_sel;
  assign occlusion_en = s.occl;
  assign err_diffusion_en = s.diff;
  assign zoom_replicate = s.zrep;
  assign cfg_conflict = s.confl;
  assign fmt_sel = s.fmt;
  assign yuv12_assist = s.y12;
  assign host_irq_pin = s.irq;
  assign irq_pending_reg = s.pend;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // all checks on clk_sys, idle in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // window enable timing
  enable_on_vsync_a: assert property (
    $rose(s.win_en) |-> $past(vs_rise)) else $error("window enabled off vsync");
  disable_now_a: assert property (
    !s.mctl[VWO_MC_EN_BIT] |=> !s.win_en) else $error("window not disabled");

  // capture address stepping
  cap_aligned_a: assert property (
    capture_addr[1:0] == 2'h0) else $error("capture address not aligned");
  luma_step_a: assert property (
    s.luma_only && cap_line_end && !ref_fall |=> capture_addr ==
      (($past(s.cap_addr) + VWO_LUMA_OFFSET) & 22'h3f_fffc))
    else $error("luma capture step wrong");
  inter_step_a: assert property (
    cap_line_end && cap_interleave && !s.luma_only && !ref_fall |=> capture_addr ==
      (($past(s.cap_addr) + {$past(line_offs[20:0]), 1'b0}) & 22'h3f_fffc))
    else $error("interleave step wrong");

  // capture buffer choice per field
  buf_swap_a: assert property (
    ref_fall && dbl_buf_en |=> capture_buf_one != $past(s.cap_sel)) else $error("no swap");
  cap_default_a: assert property (
    ref_fall && !dbl_buf_en |=> !capture_buf_one) else $error("capture not on buffer two");

  // window line stepping
  line_add_a: assert property (
    line_strobe && s.win_act && !vs_rise |=> window_addr ==
      $past(s.win_addr) + $past(line_offs)) else $error("window line step wrong");

  // interrupt pending and source
  pend_clear_a: assert property (
    !s.misc[VWO_MS_IRQEN_BIT] |=> !irq_pending_reg) else $error("pending not cleared");
  pend_set_a: assert property (
    s.misc[VWO_MS_IRQEN_BIT] && ref_fall |=> irq_pending_reg)
    else $error("pending not set");
  irq_source_a: assert property (
    !s.misc[VWO_MS_SRC_BIT] ##1 !s.misc[VWO_MS_SRC_BIT] |-> host_irq_pin == $past(vsync))
    else $error("irq source wrong");

  // aperture decimation
  decim_a: assert property (
    ap_wr && adec_rgb && ap_be == VWO_BE_DWORD |=> mem_wr && mem_be == 4'h3 &&
      mem_addr[20:0] == $past(ap_offset[21:1])) else $error("decimation wrong");

  // status bits and reads
  field_toggle_a: assert property (
    ref_fall |=> s.field_id != $past(s.field_id)) else $error("field id not toggled");
  misc_bit3_a: assert property (
    io_rd && io_index == VWO_IDX_MISC_CTL |=> !io_rdata[3]) else $error("bit 3 not zero");
  ref_level_a: assert property (
    io_rd && io_index == VWO_IDX_MISC_CTL |=> io_rdata[VWO_MS_REF_BIT] == $past(s.ref_s2))
    else $error("reference level not shown");

  // mode bits are plain copies
  occl_copy_a: assert property (
    occlusion_en == $past(s.mctl[VWO_MC_OCCL_BIT])) else $error("occlusion not copied");

  // main scenarios
  enable_c: cover property (vs_rise && s.mctl[VWO_MC_EN_BIT] ##1 s.win_en);
  swap_c: cover property (ref_fall && dbl_buf_en ##1 capture_buf_one);
  irq_c: cover property (s.misc[VWO_MS_SRC_BIT] && irq_pending_reg ##1 host_irq_pin);
  decim_c: cover property (ap_wr && adec_rgb ##1 mem_wr);
  window_c: cover property (line_strobe && s.win_act ##1 window_active);


endmodule

// file: tb/vwo_control_tb_top.sv
// vwo_control_tb_top: self-checking bench for the video overlay window control block.
// assumes the register file and address logic run on clk_sys and inputs change at its rise.
module vwo_control_tb_top
  import vwo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] idx;   // register index
    logic [7:0] wdata; // value written
    logic [7:0] rexp;  // value expected back
  } vwo_row_t;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] io_index = 8'h00, io_wdata = 8'h00;
  logic io_wr = 1'b0, io_rd = 1'b0, vsync = 1'b0, line_strobe = 1'b0;
  logic field_ref_pin = 1'b1;  // idles high, active edge is the fall
  logic dbl_buf_en = 1'b0, cap_interleave = 1'b0, cap_line_end = 1'b0, ap_wr = 1'b0;
  logic [21:0] ap_offset = 22'h00_0000;
  logic [3:0] ap_be = 4'h0;
  logic [31:0] ap_data = 32'h0000_0000;
  logic [7:0] io_rdata;
  logic mem_wr, window_active, capture_buf_one, occlusion_en, err_diffusion_en;
  logic zoom_replicate, cfg_conflict, yuv12_assist, host_irq_pin, irq_pending_reg;
  logic [21:0] mem_addr, window_addr, capture_addr;
  logic [3:0] mem_be;
  logic [31:0] mem_data;
  logic [5:0] fmt_sel;
  int checked = 0;
  int bad_count = 0;

  // register rows: index, written value, value read back
  vwo_row_t rows [14] = '{
    '{8'h37, 8'hff, 8'hff},
    '{8'h38, 8'ha5, 8'ha5},
    '{8'h39, 8'hff, 8'h0f},
    '{8'h3a, 8'h12, 8'h12},
    '{8'h3b, 8'h34, 8'h34},
    '{8'h3c, 8'hff, 8'h2f},
    '{8'h3d, 8'h81, 8'h81},
    '{8'h58, 8'h0a, 8'h0a},
    '{8'h59, 8'h56, 8'h56},
    '{8'h5a, 8'h78, 8'h78},
    '{8'h5c, 8'h80, 8'h80},
    '{8'h5d, 8'h0f, 8'h0f},
    '{8'h3e, 8'h4e, 8'h0e},
    '{8'h3f, 8'hf7, 8'hb3}};

  // ----------------------------------------------------------------------
  // clock and device under test
  // ----------------------------------------------------------------------
  always #2 clk_sys = ~clk_sys;

  vwo_control dut (
    .clk_sys(clk_sys), .reset(reset), .io_index(io_index), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .vsync(vsync),
    .line_strobe(line_strobe), .field_ref_pin(field_ref_pin), .dbl_buf_en(dbl_buf_en),
    .cap_interleave(cap_interleave), .cap_line_end(cap_line_end), .ap_wr(ap_wr),
    .ap_offset(ap_offset), .ap_be(ap_be), .ap_data(ap_data), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_data(mem_data),
    .window_active(window_active), .window_addr(window_addr),
    .capture_addr(capture_addr), .capture_buf_one(capture_buf_one),
    .occlusion_en(occlusion_en), .err_diffusion_en(err_diffusion_en),
    .zoom_replicate(zoom_replicate), .cfg_conflict(cfg_conflict), .fmt_sel(fmt_sel),
    .yuv12_assist(yuv12_assist), .host_irq_pin(host_irq_pin),
    .irq_pending_reg(irq_pending_reg));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // one-hot decode expected for each display format code
  function automatic logic [5:0] fmt_exp(input logic [2:0] f);
    case (f)
      VWO_FMT_YUV422: fmt_exp = 6'h01;
      VWO_FMT_COMPRESSED: fmt_exp = 6'h02;
      VWO_FMT_LUT8: fmt_exp = 6'h04;
      VWO_FMT_RGB555: fmt_exp = 6'h08;
      VWO_FMT_RGB565: fmt_exp = 6'h10;
      default: fmt_exp = 6'h20;  // reserved codes
    endcase
  endfunction

  // compare a value, count it, report a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  // let registered outputs land, then step off the edge
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    io_index <= i;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask

  // one-cycle register read, data sampled once it stands
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    @(posedge clk_sys);
    io_index <= i;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(posedge clk_sys);
    #1;
    v = io_rdata;
  endtask

  // one-cycle pulse: 0 end of scanline, 1 end of captured line
  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) line_strobe <= 1'b1;
    else cap_line_end <= 1'b1;
    @(posedge clk_sys);
    line_strobe <= 1'b0;
    cap_line_end <= 1'b0;
  endtask

  // aperture write, checks whether a memory write follows one cycle later
  task automatic ap(input logic [21:0] o, input logic [3:0] be, input logic exp_wr);
    @(posedge clk_sys);
    ap_offset <= o;
    ap_be <= be;
    ap_data <= 32'hdead_beef;
    ap_wr <= 1'b1;
    @(posedge clk_sys);
    ap_wr <= 1'b0;
    #1;
    chk(32'(mem_wr), 32'(exp_wr));
  endtask

  // bounded wait for the window state; running out ends the run
  task automatic wait_act(input logic e);
    #1;
    for (int k = 0; k < 8 && window_active !== e; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (window_active !== e) begin
      bad_count++;
      conclude();
    end
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [2:0] fc;
    logic [21:0] b1, b2, off, aoff;
    b1 = {4'hf, 8'h34, 8'h12, 2'b11};  // buffer one start from the rows
    b2 = {4'ha, 8'h78, 8'h56, 2'b11};  // buffer two start from the rows
    off = {10'h000, 1'b1, 8'h81, 3'h0};  // line offset, low bits zero
    aoff = 22'h00_1234;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    chk(32'(fmt_sel), 32'h0000_0001);
    chk(32'({window_active, host_irq_pin, irq_pending_reg}), 32'h0000_0000);
    rd(VWO_IDX_MISC_CTL, v);
    chk(32'(v), 32'h0000_0080);
    end_test("reset");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wdata);
      rd(rows[i].idx, v);
      chk(32'(v), 32'(rows[i].rexp));
    end
    rd(8'h40, v);
    chk(32'(v), 32'h0000_0000);
    end_test("registers");
    for (int f = 0; f < 8; f++) begin
      fc = 3'(f);
      // occlusion, diffusion and zoom bits taken from the format code bits, window enable off
      wr(VWO_IDX_MASTER_CTL, {fc[0], 1'b0, fc[1], fc[2], fc, 1'b0});
      settle();
      chk(32'(fmt_sel), 32'(fmt_exp(fc)));
      chk(32'({occlusion_en, err_diffusion_en, zoom_replicate}), 32'({fc[0], fc[1], fc[2]}));
      chk(32'(cfg_conflict), 32'(fc[0] & ~fc[2]));
      chk(32'(yuv12_assist), 32'(fc == 3'h0));
    end
    end_test("formats");
    wr(VWO_IDX_MISC_CTL, 8'h00);
    wr(VWO_IDX_VSTART_LOW, 8'h02);
    wr(VWO_IDX_VEND_LOW, 8'h03);
    wr(VWO_IDX_VERT_OVF, 8'h00);
    wr(VWO_IDX_MASTER_CTL, 8'h01);
    @(posedge clk_sys);
    vsync <= 1'b1;
    settle();
    chk(32'(window_addr), 32'(b1));
    chk(32'(host_irq_pin), 32'h0000_0001);
    pulse(0);
    settle();
    chk(32'(window_active), 32'h0000_0000);
    pulse(0);
    wait_act(1'b1);
    chk(32'(window_addr), 32'(b1));
    pulse(0);
    settle();
    chk(32'({window_active, window_addr}), 32'({1'b1, b1 + off}));
    wr(VWO_IDX_MASTER_CTL, 8'h00);
    settle();
    chk(32'(window_active), 32'h0000_0000);
    wr(VWO_IDX_MASTER_CTL, 8'h01);
    settle();
    chk(32'(window_active), 32'h0000_0000);
    @(posedge clk_sys);
    vsync <= 1'b0;
    end_test("window");
    wr(VWO_IDX_MISC_CTL, 8'h22);
    @(posedge clk_sys);
    field_ref_pin <= 1'b0;
    settle();
    settle();
    chk(32'(capture_addr), 32'(b2 & ~22'h00_0003));
    chk(32'({capture_buf_one, irq_pending_reg, host_irq_pin}), 32'h0000_0003);
    rd(VWO_IDX_MISC_CTL, v);
    chk(32'(v), 32'h0000_0062);
    pulse(1);
    settle();
    chk(32'(capture_addr), 32'((b2 & ~22'h00_0003) + VWO_LUMA_OFFSET));
    wr(VWO_IDX_LUMA_ONLY, 8'h00);
    @(posedge clk_sys);
    cap_interleave <= 1'b1;
    pulse(1);
    settle();
    chk(32'(capture_addr), 32'((b2 & ~22'h00_0003) + VWO_LUMA_OFFSET + 2 * off));
    @(posedge clk_sys);
    cap_interleave <= 1'b0;
    pulse(1);
    settle();
    chk(32'(capture_addr), 32'((b2 & ~22'h00_0003) + VWO_LUMA_OFFSET + 3 * off));
    wr(VWO_IDX_MISC_CTL, 8'h20);
    settle();
    chk(32'({irq_pending_reg, host_irq_pin}), 32'h0000_0000);
    @(posedge clk_sys);
    dbl_buf_en <= 1'b1;
    field_ref_pin <= 1'b1;
    settle();
    @(posedge clk_sys);
    field_ref_pin <= 1'b0;
    settle();
    settle();
    chk(32'({capture_buf_one, irq_pending_reg}), 32'h0000_0002);
    chk(32'(capture_addr), 32'(b1 & ~22'h00_0003));
    rd(VWO_IDX_MISC_CTL, v);
    chk(32'(v), 32'h0000_0024);
    end_test("capture");
    wr(VWO_IDX_MISC_CTL, 8'h11);
    wr(VWO_IDX_MASTER_CTL, 8'h08);
    ap(aoff, 4'h3, 1'b1);
    chk(32'({mem_be, mem_addr}), 32'({4'h3, 1'b1, aoff[21:1]}));
    chk(32'(mem_data[15:0]), 32'h0000_beef);
    ap(aoff, 4'h1, 1'b0);
    ap(aoff, 4'hf, 1'b1);
    chk(32'(mem_be), 32'h0000_0003);
    wr(VWO_IDX_MISC_CTL, 8'h00);
    ap(aoff, 4'hc, 1'b1);
    chk(32'({mem_be, mem_addr}), 32'({4'hc, aoff}));
    chk(mem_data, 32'hdead_beef);
    end_test("aperture");
    conclude();
  end
endmodule
